// ==== src/sfrs_pkg.sv ====
package sfrs_pkg;

   // Clock and the slow tick that times every delay
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned TICK_PERIOD_MS = 1;
   localparam int unsigned TICK_CYCLES =
      TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

   // Delays as printed and as a count of ticks (the request filter in ticks only), and the restart limit
   localparam int unsigned RETRY_OFF_S = 10;
   localparam int unsigned RETRY_OFF_TICKS =
      RETRY_OFF_S * 1000 / TICK_PERIOD_MS;
   localparam int unsigned HICCUP_OFF_S = 1;
   localparam int unsigned HICCUP_OFF_TICKS =
      HICCUP_OFF_S * 1000 / TICK_PERIOD_MS;
   localparam int unsigned STATIC_OC_BLANK_MS = 20;
   localparam int unsigned STATIC_OC_BLANK_TICKS =
      STATIC_OC_BLANK_MS / TICK_PERIOD_MS;
   localparam int unsigned SHORT_LATCH_MS = 10;
   localparam int unsigned SHORT_LATCH_TICKS =
      SHORT_LATCH_MS / TICK_PERIOD_MS;
   localparam int unsigned SETTLE_MS = 10;
   localparam int unsigned SETTLE_TICKS = SETTLE_MS / TICK_PERIOD_MS;
   localparam int unsigned REQ_STABLE_TICKS = 2;
   localparam int unsigned RETRY_LIMIT = 5;

   // Counter widths
   localparam int unsigned DIV_W = 18;
   localparam int unsigned TIMER_W = 14;
   localparam int unsigned RETRY_W = 3;
   localparam int unsigned BLANK_W = 5;
   localparam int unsigned REQ_W = 2;

   // Positions in the synchronised flag vector
   localparam int unsigned IN_INPUT_OK = 0;
   localparam int unsigned IN_REQ_N = 1;
   localparam int unsigned IN_M_OV = 2;
   localparam int unsigned IN_M_UV = 3;
   localparam int unsigned IN_M_DEV = 4;
   localparam int unsigned IN_M_OC_NOM = 5;
   localparam int unsigned IN_M_OC_DER = 6;
   localparam int unsigned IN_AMB_HOT = 7;
   localparam int unsigned IN_M_OL = 8;
   localparam int unsigned IN_M_SHORT = 9;
   localparam int unsigned IN_SB_OV = 10;
   localparam int unsigned IN_SB_UV = 11;
   localparam int unsigned IN_SB_DEV = 12;
   localparam int unsigned IN_SB_OC = 13;
   localparam int unsigned IN_OT_LO = 14;
   localparam int unsigned IN_W = 18;

   typedef enum logic [3:0] {
      SFRS_ON     = 4'h1,
      SFRS_RETRY  = 4'h2,
      SFRS_HICCUP = 4'h4,
      SFRS_LATCH  = 4'h8
   } sfrs_state_t;

endpackage

// ==== src/sfrs_chan.sv ====
`timescale 1ns/1ps
module sfrs_chan #(
   parameter int unsigned OFF_TICKS = sfrs_pkg::RETRY_OFF_TICKS,
   parameter int unsigned HICCUP_TICKS = sfrs_pkg::HICCUP_OFF_TICKS,
   parameter int unsigned RETRY_MAX = sfrs_pkg::RETRY_LIMIT,
   parameter int unsigned SETTLE = sfrs_pkg::SETTLE_TICKS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic clear,
   input wire logic allow,
   input wire logic fault,
   input wire logic uv,
   input wire logic hiccup,
   output logic on,
   output logic settled,
   output logic latched,
   output logic [sfrs_pkg::RETRY_W-1:0] retries
);
   localparam int unsigned TW = sfrs_pkg::TIMER_W;

   if (OFF_TICKS < 1 || OFF_TICKS >= 2**TW || HICCUP_TICKS < 1 ||
       HICCUP_TICKS >= 2**TW || SETTLE >= 2**TW ||
       RETRY_MAX >= 2**sfrs_pkg::RETRY_W) begin : g_bad
      $error("sfrs_chan: parameter out of range");
   end

   sfrs_pkg::sfrs_state_t state, next_state;
   logic [TW-1:0] timer, next_timer;
   logic [sfrs_pkg::RETRY_W-1:0] next_retries;

   assign on = (state == sfrs_pkg::SFRS_ON);
   assign settled = on && (timer == TW'(SETTLE));
   assign latched = (state == sfrs_pkg::SFRS_LATCH);

   always_comb begin
      next_state = state;
      next_timer = timer;
      next_retries = retries;
      if (clear) begin
         next_state = sfrs_pkg::SFRS_ON;
         next_timer = '0;
         next_retries = '0;
      end else begin
         unique case (state)
            sfrs_pkg::SFRS_ON: begin
               if (!allow) begin
                  next_timer = '0;
               end else if (fault || (uv && settled)) begin
                  next_timer = '0;
                  if (retries == RETRY_W_MAX()) begin
                     next_state = sfrs_pkg::SFRS_LATCH;
                  end else begin
                     next_state = sfrs_pkg::SFRS_RETRY;
                  end
               end else if (hiccup) begin
                  next_state = sfrs_pkg::SFRS_HICCUP;
                  next_timer = '0;
               end else if (tick && timer != TW'(SETTLE)) begin
                  next_timer = timer + 1'h1;
               end
            end
            sfrs_pkg::SFRS_RETRY: begin
               if (tick) begin
                  next_timer = timer + 1'h1;
                  if (timer + 1'h1 >= TW'(OFF_TICKS)) begin
                     next_state = sfrs_pkg::SFRS_ON;
                     next_timer = '0;
                     next_retries = retries + 1'h1;
                  end
               end
            end
            sfrs_pkg::SFRS_HICCUP: begin
               // Hiccup restarts are not counted toward the latch
               if (tick) begin
                  next_timer = timer + 1'h1;
                  if (timer + 1'h1 >= TW'(HICCUP_TICKS)) begin
                     next_state = sfrs_pkg::SFRS_ON;
                     next_timer = '0;
                  end
               end
            end
            sfrs_pkg::SFRS_LATCH: begin
               next_state = sfrs_pkg::SFRS_LATCH;
            end
            default: begin
               next_state = sfrs_pkg::SFRS_LATCH;
            end
         endcase
      end
   end

   function automatic logic [sfrs_pkg::RETRY_W-1:0] RETRY_W_MAX();
      RETRY_W_MAX = sfrs_pkg::RETRY_W'(RETRY_MAX);
   endfunction

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= sfrs_pkg::SFRS_ON;
         timer <= '0;
         retries <= '0;
      end else begin
         state <= next_state;
         timer <= next_timer;
         retries <= next_retries;
      end
   end

   a_latch_count: assert property (@(posedge clk) disable iff (rst)
      $rose(latched) |-> retries == RETRY_W_MAX())
      else $error("latched before the restart budget was used");
   a_hiccup_free: assert property (@(posedge clk) disable iff (rst)
      (state == sfrs_pkg::SFRS_HICCUP && !clear) |=>
         retries == $past(retries))
      else $error("hiccup restart changed the retry count");
   c_hiccup: cover property (@(posedge clk) disable iff (rst)
      state == sfrs_pkg::SFRS_HICCUP ##1 state == sfrs_pkg::SFRS_ON);

endmodule // sfrs_chan

// ==== src/sfrs_top.sv ====
`timescale 1ns/1ps
module sfrs_top #(
   parameter int unsigned TICK_CYCLES = sfrs_pkg::TICK_CYCLES,
   parameter int unsigned RETRY_OFF_TICKS = sfrs_pkg::RETRY_OFF_TICKS,
   parameter int unsigned HICCUP_OFF_TICKS = sfrs_pkg::HICCUP_OFF_TICKS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic input_power_ok,
   input wire logic power_on_request_n,
   input wire logic main_ov,
   input wire logic main_uv,
   input wire logic main_deviation,
   input wire logic main_over_static_limit,
   input wire logic main_over_derated_limit,
   input wire logic ambient_above_45c,
   input wire logic main_at_overload_limit,
   input wire logic main_short,
   input wire logic standby_ov,
   input wire logic standby_uv,
   input wire logic standby_deviation,
   input wire logic standby_at_current_limit,
   input wire logic [3:0] over_temperature,
   output logic main_enable,
   output logic standby_enable,
   output logic main_voltage_foldback,
   output logic power_good_n,
   output logic alert_n,
   output logic status_fault_lamp
);
   if (TICK_CYCLES < 2 || TICK_CYCLES >= 2**sfrs_pkg::DIV_W)
   begin : g_bad
      $error("sfrs_top: TICK_CYCLES out of range");
   end

   // Two-stage synchroniser; only s_in is read by logic
   logic [sfrs_pkg::IN_W-1:0] raw, sync_a, s_in;
   assign raw = {over_temperature, standby_at_current_limit,
                 standby_deviation, standby_uv, standby_ov, main_short,
                 main_at_overload_limit, ambient_above_45c,
                 main_over_derated_limit, main_over_static_limit,
                 main_deviation, main_uv, main_ov, power_on_request_n,
                 input_power_ok};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_a <= '0;
         s_in <= '0;
      end else begin
         sync_a <= raw;
         s_in <= sync_a;
      end
   end

   logic in_ok, s_m_ov, s_m_uv, s_m_dev, s_m_ol, s_m_short, s_sb_ov;
   logic s_sb_uv, s_sb_dev, s_sb_oc, ot_any, m_oc;
   assign in_ok = s_in[sfrs_pkg::IN_INPUT_OK];
   assign s_m_ov = s_in[sfrs_pkg::IN_M_OV];
   assign s_m_uv = s_in[sfrs_pkg::IN_M_UV];
   assign s_m_dev = s_in[sfrs_pkg::IN_M_DEV];
   assign s_m_ol = s_in[sfrs_pkg::IN_M_OL];
   assign s_m_short = s_in[sfrs_pkg::IN_M_SHORT];
   assign s_sb_ov = s_in[sfrs_pkg::IN_SB_OV];
   assign s_sb_uv = s_in[sfrs_pkg::IN_SB_UV];
   assign s_sb_dev = s_in[sfrs_pkg::IN_SB_DEV];
   assign s_sb_oc = s_in[sfrs_pkg::IN_SB_OC];
   assign ot_any = |s_in[sfrs_pkg::IN_OT_LO +: 4];
   // Hot inlet selects the lower, derated comparator
   assign m_oc = s_in[sfrs_pkg::IN_AMB_HOT] ?
                 s_in[sfrs_pkg::IN_M_OC_DER] :
                 s_in[sfrs_pkg::IN_M_OC_NOM];

   // Millisecond tick divider
   logic [sfrs_pkg::DIV_W-1:0] div, next_div;
   logic tick, next_tick;
   always_comb begin
      next_tick = (div == sfrs_pkg::DIV_W'(TICK_CYCLES - 1));
      next_div = next_tick ? '0 : div + 1'h1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div <= '0;
         tick <= 1'h0;
      end else begin
         div <= next_div;
         tick <= next_tick;
      end
   end

   // Request filter: a level counts only after two stable ticks
   logic req_n_filt, next_req_n_filt, clear_req;
   logic [sfrs_pkg::REQ_W-1:0] req_cnt, next_req_cnt;
   always_comb begin
      next_req_n_filt = req_n_filt;
      next_req_cnt = req_cnt;
      if (s_in[sfrs_pkg::IN_REQ_N] == req_n_filt) begin
         next_req_cnt = '0;
      end else if (tick) begin
         next_req_cnt = req_cnt + 1'h1;
         if (req_cnt + 1'h1 >=
             sfrs_pkg::REQ_W'(sfrs_pkg::REQ_STABLE_TICKS)) begin
            next_req_n_filt = s_in[sfrs_pkg::IN_REQ_N];
            next_req_cnt = '0;
         end
      end
   end
   // Clearing on reassertion means a toggle that passes the filter ends in a fresh start
   assign clear_req = req_n_filt && !next_req_n_filt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_n_filt <= 1'h1;
         req_cnt <= '0;
      end else begin
         req_n_filt <= next_req_n_filt;
         req_cnt <= next_req_cnt;
      end
   end

   // Main current blanking and short-circuit timers
   logic m_on, m_settled, m_latched, sb_on, sb_settled, sb_latched;
   logic [sfrs_pkg::RETRY_W-1:0] m_retries, sb_retries;
   logic [sfrs_pkg::BLANK_W-1:0] oc_cnt, next_oc_cnt, sc_cnt, next_sc_cnt;
   logic oc_trip, sc_trip, main_allow, clear;
   assign main_allow = in_ok && !req_n_filt;
   assign clear = !in_ok || clear_req;
   assign oc_trip =
      oc_cnt > sfrs_pkg::BLANK_W'(sfrs_pkg::STATIC_OC_BLANK_TICKS);
   assign sc_trip =
      sc_cnt >= sfrs_pkg::BLANK_W'(sfrs_pkg::SHORT_LATCH_TICKS);
   always_comb begin
      next_oc_cnt = '0;
      next_sc_cnt = '0;
      if (m_on && main_allow && m_oc) begin
         // Slow or brief overload rides through the blanking window
         next_oc_cnt = (tick && !oc_trip) ? oc_cnt + 1'h1 : oc_cnt;
      end
      if (m_on && main_allow && s_m_short) begin
         next_sc_cnt = (tick && !sc_trip) ? sc_cnt + 1'h1 : sc_cnt;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oc_cnt <= '0;
         sc_cnt <= '0;
      end else begin
         oc_cnt <= next_oc_cnt;
         sc_cnt <= next_sc_cnt;
      end
   end

   // One sequencer per output keeps faults local
   sfrs_chan #(
      .OFF_TICKS(RETRY_OFF_TICKS),
      .HICCUP_TICKS(HICCUP_OFF_TICKS),
      .RETRY_MAX(sfrs_pkg::RETRY_LIMIT),
      .SETTLE(sfrs_pkg::SETTLE_TICKS)
   ) u_main (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .clear(clear),
      .allow(main_allow),
      .fault(s_m_ov || ot_any || oc_trip || sc_trip),
      .uv(s_m_uv),
      .hiccup(1'h0),
      .on(m_on),
      .settled(m_settled),
      .latched(m_latched),
      .retries(m_retries)
   );

   sfrs_chan #(
      .OFF_TICKS(RETRY_OFF_TICKS),
      .HICCUP_TICKS(HICCUP_OFF_TICKS),
      .RETRY_MAX(sfrs_pkg::RETRY_LIMIT),
      .SETTLE(sfrs_pkg::SETTLE_TICKS)
   ) u_standby (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .clear(clear),
      .allow(in_ok),
      .fault(s_sb_ov || ot_any),
      .uv(s_sb_uv),
      .hiccup(s_sb_oc),
      .on(sb_on),
      .settled(sb_settled),
      .latched(sb_latched),
      .retries(sb_retries)
   );

   // Registered pin outputs
   logic next_m_en, next_sb_en, next_fold, next_pg_n, next_alert_n;
   logic next_lamp, dev_any;
   always_comb begin
      next_m_en = m_on && main_allow;
      next_sb_en = sb_on && in_ok;
      next_fold = next_m_en && s_m_ol;
      dev_any = (next_m_en && s_m_dev) || (next_sb_en && s_sb_dev);
      next_pg_n = !(next_m_en && next_sb_en && m_settled && sb_settled &&
                    !dev_any);
      next_lamp = dev_any || m_latched || sb_latched ||
                  (main_allow && !m_on) || (in_ok && !sb_on);
      next_alert_n = !(next_lamp || next_fold || ot_any);
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         main_enable <= 1'h0;
         standby_enable <= 1'h0;
         main_voltage_foldback <= 1'h0;
         power_good_n <= 1'h1;
         alert_n <= 1'h1;
         status_fault_lamp <= 1'h0;
      end else begin
         main_enable <= next_m_en;
         standby_enable <= next_sb_en;
         main_voltage_foldback <= next_fold;
         power_good_n <= next_pg_n;
         alert_n <= next_alert_n;
         status_fault_lamp <= next_lamp;
      end
   end

   a_ov_main_off: assert property (@(posedge clk) disable iff (rst)
      (s_m_ov && m_on) |-> ##[1:2] !main_enable)
      else $error("main stayed on after overvoltage");
   a_pg_dev_high: assert property (@(posedge clk) disable iff (rst)
      (s_sb_dev && sb_on && in_ok) |=> power_good_n)
      else $error("power good asserted during deviation");
   a_pg_needs_both: assert property (@(posedge clk) disable iff (rst)
      !power_good_n |-> (main_enable && standby_enable))
      else $error("power good without both outputs on");
   a_alert_fault: assert property (@(posedge clk) disable iff (rst)
      (ot_any || m_latched) |=> !alert_n)
      else $error("alert released in failure");
   a_fold_follow: assert property (@(posedge clk) disable iff (rst)
      (next_m_en && s_m_ol) |=> main_voltage_foldback ##0
      main_enable)
      else $error("no foldback at overload limit");
   a_sb_hiccup_off: assert property (@(posedge clk) disable iff (rst)
      (s_sb_oc && sb_on && in_ok) |-> ##[1:2] !standby_enable)
      else $error("standby not cut on overcurrent");
   a_clear_counts: assert property (@(posedge clk) disable iff (rst)
      clear |=> (m_retries == '0 && sb_retries == '0))
      else $error("clear left a retry count");
   a_oc_blanking: assert property (@(posedge clk) disable iff (rst)
      (oc_cnt == sfrs_pkg::BLANK_W'(sfrs_pkg::STATIC_OC_BLANK_TICKS) &&
       m_oc && m_on && main_allow && tick)
      |=> oc_trip)
      else $error("static overcurrent not tripped after blanking");
   a_isolated_fault: assert property (@(posedge clk) disable iff (rst)
      (s_m_ov && m_on && main_allow && !ot_any && sb_on && in_ok &&
       !s_sb_ov && !s_sb_oc && !clear) |=> sb_on)
      else $error("main fault disturbed standby");

   c_main_latch: cover property (@(posedge clk) disable iff (rst)
      $rose(m_latched));
   c_request_clear: cover property (@(posedge clk) disable iff (rst)
      clear_req && m_latched);
   c_foldback: cover property (@(posedge clk) disable iff (rst)
      $rose(main_voltage_foldback));

endmodule // sfrs_top

// ==== sim/sfrs_host.sv ====
`timescale 1ns/1ps
// Host power controller: holds the active-low request, and on command
// releases it high for hold clocks before asserting it again. A hold of
// one clock is a glitch that the supply must not take as a toggle.
module sfrs_host (
   input wire logic clk,
   input wire logic rst,
   input wire logic want_on,
   input wire logic toggle,
   input wire logic [7:0] hold,
   output logic power_on_request_n,
   output logic busy
);
   logic [7:0] left;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         left <= 8'h00;
      end else if (toggle && left == 8'h00) begin
         left <= hold;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end

   assign busy = (left != 8'h00);
   assign power_on_request_n = busy || !want_on;
endmodule // sfrs_host

// ==== sim/test_sfrs_top.sv ====
`timescale 1ns/1ps
module test_sfrs_top;
   // Short tick and retry counts keep the run small
   localparam int TK = 4;
   localparam int RT = 5;
   localparam int HT = 3;
   localparam int LIMIT = 20000;
   logic clk, rst, input_power_ok, want_on, toggle, busy;
   logic [7:0] hold;
   // Flag positions follow the package's flag vector
   logic [17:0] f;
   logic power_on_request_n, main_enable, standby_enable;
   logic main_voltage_foldback, power_good_n, alert_n, status_fault_lamp;
   int miscompares, checks, cyc;

   sfrs_top #(.TICK_CYCLES(TK), .RETRY_OFF_TICKS(RT),
         .HICCUP_OFF_TICKS(HT)) uut (
      .clk(clk), .rst(rst), .input_power_ok(input_power_ok),
      .power_on_request_n(power_on_request_n),
      .main_ov(f[2]), .main_uv(f[3]), .main_deviation(f[4]),
      .main_over_static_limit(f[5]), .main_over_derated_limit(f[6]),
      .ambient_above_45c(f[7]), .main_at_overload_limit(f[8]),
      .main_short(f[9]), .standby_ov(f[10]), .standby_uv(f[11]),
      .standby_deviation(f[12]), .standby_at_current_limit(f[13]),
      .over_temperature(f[17:14]), .main_enable(main_enable),
      .standby_enable(standby_enable),
      .main_voltage_foldback(main_voltage_foldback),
      .power_good_n(power_good_n), .alert_n(alert_n),
      .status_fault_lamp(status_fault_lamp));

   sfrs_host host (
      .clk(clk), .rst(rst), .want_on(want_on), .toggle(toggle),
      .hold(hold), .power_on_request_n(power_on_request_n), .busy(busy));

   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask

   task automatic cyc_n(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Waits until both enables match; n returns the clocks waited
   task automatic wait_en(input logic m, input logic s, input int lim,
         output int n);
      n = 0;
      while ((main_enable !== m || standby_enable !== s) && n <= lim) begin
         @(negedge clk);
         n++;
      end
      chk(n <= lim, 1'h1, "enable change late or missing");
   endtask

   task automatic toggle_req(input logic [7:0] len);
      hold = len;
      toggle = 1'h1;
      @(negedge clk);
      toggle = 1'h0;
   endtask

   // Input loss then restore: also the clearing path for latch and count
   task automatic power_up();
      int n;
      f = '0;
      want_on = 1'h1;
      input_power_ok = 1'h0;
      cyc_n(2 * TK);
      wait_en(1'h0, 1'h0, 0, n);
      input_power_ok = 1'h1;
      wait_en(1'h1, 1'h1, 8 * TK, n);
      repeat (16 * TK) if (power_good_n !== 1'h0) @(negedge clk);
      chk(power_good_n, 1'h0, "power good not asserted");
      chk(alert_n, 1'h1, "alert while healthy");
      chk(status_fault_lamp, 1'h0, "lamp while healthy");
   endtask

   task automatic fault_table();
      int idx[8] = '{2, 3, 10, 11, 14, 15, 16, 17};
      int n;
      logic m_exp, s_exp;
      for (int i = 0; i < 8; i++) begin
         power_up();
         f[idx[i]] = 1'h1;
         // Main or standby fault alone, or heat on both
         m_exp = idx[i] inside {[10:13]};
         s_exp = idx[i] < 10;
         wait_en(m_exp, s_exp, TK, n);
         chk(power_good_n, 1'h1, "power good during fault");
         chk(alert_n, 1'h0, "no alert on fault");
         f[idx[i]] = 1'h0;
         wait_en(1'h1, 1'h1, (RT + 2) * TK, n);
         chk(n >= (RT - 1) * TK, 1'h1, "restart too early");
      end
   endtask

   task automatic deviation();
      for (int i = 4; i <= 12; i += 8) begin
         power_up();
         f[i] = 1'h1;
         cyc_n(5);
         chk(power_good_n, 1'h1, "power good with deviation");
         chk(status_fault_lamp, 1'h1, "lamp off with deviation");
         chk(main_enable, 1'h1, "main dropped");
         chk(standby_enable, 1'h1, "standby dropped");
         f[i] = 1'h0;
         cyc_n(5);
         chk(power_good_n, 1'h0, "power good not back");
      end
   endtask

   task automatic foldback();
      power_up();
      f[8] = 1'h1;
      cyc_n(4);
      chk(main_voltage_foldback, 1'h1, "no foldback");
      chk(main_enable, 1'h1, "main shut by overload");
      f[8] = 1'h0;
      cyc_n(4);
      chk(main_voltage_foldback, 1'h0, "foldback stuck");
   endtask

   // Nominal limit, derated limit when hot, derated comparator when cool
   task automatic static_oc();
      int n;
      for (int i = 0; i < 3; i++) begin
         power_up();
         f[7] = (i == 1);
         f[i == 0 ? 5 : 6] = 1'h1;
         cyc_n(20 * TK);
         chk(main_enable, 1'h1, "overcurrent tripped early");
         if (i == 2) cyc_n(8 * TK);
         else wait_en(1'h0, 1'h1, 6 * TK, n);
         chk(main_enable, i == 2, "derated limit selection");
      end
   endtask

   task automatic short_main();
      int n;
      power_up();
      f[9] = 1'h1;
      cyc_n(8 * TK);
      chk(main_enable, 1'h1, "short tripped early");
      wait_en(1'h0, 1'h1, 4 * TK, n);
      f[9] = 1'h0;
   endtask

   task automatic hiccup();
      int n, rises;
      logic last;
      power_up();
      f[13] = 1'h1;
      wait_en(1'h1, 1'h0, TK, n);
      rises = 0;
      last = 1'h0;
      repeat (6 * (HT + 2) * TK) begin
         @(negedge clk);
         if (standby_enable === 1'h1 && last !== 1'h1) rises++;
         last = standby_enable;
      end
      // At least as many tries as the restart limit: hiccup must never latch
      chk(rises >= 5, 1'h1, "standby stopped retrying");
      chk(main_enable, 1'h1, "main hit by standby fault");
      f[13] = 1'h0;
      wait_en(1'h1, 1'h1, (HT + 2) * TK, n);
   endtask

   task automatic run_latch();
      int n;
      for (int k = 0; k < 6; k++) begin
         f[2] = 1'h1;
         wait_en(1'h0, 1'h1, TK, n);
         f[2] = 1'h0;
         if (k < 5) wait_en(1'h1, 1'h1, (RT + 2) * TK, n);
      end
      cyc_n((RT + 3) * TK);
      chk(main_enable, 1'h0, "no latch after five restarts");
   endtask

   task automatic latch_clear();
      int n;
      power_up();
      run_latch();
      toggle_req(8'h01);
      cyc_n(4 * TK);
      chk(main_enable, 1'h0, "glitch cleared the latch");
      toggle_req(8'(3 * TK));
      wait_en(1'h1, 1'h1, 12 * TK, n);
      run_latch();
      power_up();
   endtask

   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         miscompares++;
         tally_and_finish();
      end
   end

   initial begin
      rst = 1'h1;
      input_power_ok = 1'h0;
      want_on = 1'h0;
      toggle = 1'h0;
      hold = 8'h00;
      f = '0;
      miscompares = 0;
      checks = 0;
      cyc = 0;
      repeat (5) @(negedge clk);
      chk(main_enable | standby_enable, 1'h0, "enabled in reset");
      chk(power_good_n, 1'h1, "power good low in reset");
      chk(alert_n, 1'h1, "alert low in reset");
      rst = 1'h0;
      fault_table();
      deviation();
      foldback();
      static_oc();
      short_main();
      hiccup();
      latch_clear();
      tally_and_finish();
   end
endmodule // test_sfrs_top
